// *** hdl/csta_aggregator.sv ***
// Common start/trip aggregator with overrides, events, counters and IRQ.
// Assumes stage inputs and extra sources are synchronous to clk; Wishbone classic slave.
// Overview of operation
// - Any stage start drives common start.
// - Any stage trip drives common trip.
// - Software-selected extra sources also drive common start.
// - Software-selected extra sources also drive common trip.
// - Override normal, start or trip; default normal; needs force enable.
// - Override is static, independent of setting group.
// - Read-only condition shows normal, start or trip.
// - No blocking input; stages handle their own blocking.
// - Four events: start on, start off, trip on, trip off.
// - Per-event store mask decides which events reach event buffer; one per cycle, lowest index wins.
// - Each event carries the time stamp of its recording.
// - Start and trip counters increment on each ON event only; software clears them.
// - Common outputs are exported for output control and user logic.
`timescale 1ns/10ps
module csta_aggregator #(
  parameter int N_STAGES = 8,
  parameter int N_EXTRA = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Protection stages and extra sources
  input wire logic [N_STAGES-1:0] stage_start,
  input wire logic [N_STAGES-1:0] stage_trip,
  input wire logic [N_EXTRA-1:0] extra_src,
  // Setting group, ignored by the override
  input wire logic [2:0] setting_group,
  // Common outputs
  output csta_pkg::csta_common_t common_out,
  // Event buffer feed
  output logic ev_valid,
  output csta_pkg::csta_event_t ev_data,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq
);
  logic [1:0] ovr_ff;
  logic force_en_ff;
  logic [3:0] store_ff;
  logic [N_EXTRA-1:0] xstart_ff;
  logic [N_EXTRA-1:0] xtrip_ff;
  logic [31:0] tstamp_ff;
  logic [31:0] cnt_start_ff;
  logic [31:0] cnt_trip_ff;
  logic [3:0] istat_ff;
  logic [3:0] ien_ff;
  logic common_start_ff;
  logic common_trip_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic ev_valid_ff;
  csta_pkg::csta_event_t ev_ff;

  // Bus decode
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction

  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr = bus_req & wb_we_i;
  wire wr_ctrl = wr & reg_hit(wb_adr_i, csta_pkg::CSTA_CTRL_OFS) & wb_sel_i[0];
  wire wr_iclr = wr & reg_hit(wb_adr_i, csta_pkg::CSTA_ICLR_OFS) & wb_sel_i[0];
  wire wr_ien = wr & reg_hit(wb_adr_i, csta_pkg::CSTA_IEN_OFS) & wb_sel_i[0];
  wire wr_cclr = wr & reg_hit(wb_adr_i, csta_pkg::CSTA_CNT_CLR_OFS) & wb_sel_i[0];
  wire wr_xs = wr & reg_hit(wb_adr_i, csta_pkg::CSTA_EXTRA_START_OFS);
  wire wr_xt = wr & reg_hit(wb_adr_i, csta_pkg::CSTA_EXTRA_TRIP_OFS);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Clear with a coincident ON edge leaves a count of one
  function automatic logic [31:0] next_count(input logic [31:0] cur, input logic clr, input logic inc);
    logic [31:0] r;
    r = cur;
    if (clr) begin
      r = {31'h0000_0000, inc};
    end else if (inc) begin
      r = cur + 32'h0000_0001;
    end
    return r;
  endfunction

  // Combining; no blocking input exists here by design
  wire raw_start = (|stage_start) | (|(extra_src & xstart_ff));
  wire raw_trip = (|stage_trip) | (|(extra_src & xtrip_ff));
  // Override only honoured while forcing is enabled
  wire ovr_start = force_en_ff & (ovr_ff == csta_pkg::CSTA_OVR_START);
  wire ovr_trip = force_en_ff & (ovr_ff == csta_pkg::CSTA_OVR_TRIP);
  wire nxt_common_start = raw_start | ovr_start;
  wire nxt_common_trip = raw_trip | ovr_trip;

  // Trip outranks start in the condition
  wire [1:0] cond = common_trip_ff ? csta_pkg::CSTA_OVR_TRIP :
                    common_start_ff ? csta_pkg::CSTA_OVR_START : csta_pkg::CSTA_OVR_NORMAL;

  logic s_on, s_off, t_on, t_off;
  csta_edge u_start_edge (
    .clk(clk),
    .rst_b(rst_b),
    .level(common_start_ff),
    .on_pulse(s_on),
    .off_pulse(s_off)
  );
  csta_edge u_trip_edge (
    .clk(clk),
    .rst_b(rst_b),
    .level(common_trip_ff),
    .on_pulse(t_on),
    .off_pulse(t_off)
  );
  wire [3:0] ev_vec = {t_off, t_on, s_off, s_on};
  wire [3:0] ev_stored = ev_vec & store_ff;
  // Lowest event index first; start and trip edges may coincide, one report per cycle
  wire [3:0] ev_id = ev_stored[0] ? 4'h0 : ev_stored[1] ? 4'h1 : ev_stored[2] ? 4'h2 : 4'h3;

  // Read mux
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    case (wb_adr_i)
      csta_pkg::CSTA_CTRL_OFS: rd = {24'h00_0000, store_ff, 1'b0, force_en_ff, ovr_ff};
      csta_pkg::CSTA_COND_OFS: rd = {30'h0000_0000, cond};
      csta_pkg::CSTA_ISTAT_OFS: rd = {28'h000_0000, istat_ff};
      csta_pkg::CSTA_IEN_OFS: rd = {28'h000_0000, ien_ff};
      csta_pkg::CSTA_CNT_START_OFS: rd = cnt_start_ff;
      csta_pkg::CSTA_CNT_TRIP_OFS: rd = cnt_trip_ff;
      csta_pkg::CSTA_EXTRA_START_OFS: rd = 32'(xstart_ff);
      csta_pkg::CSTA_EXTRA_TRIP_OFS: rd = 32'(xtrip_ff);
      csta_pkg::CSTA_TSTAMP_OFS: rd = tstamp_ff;
      default: rd = 32'h0000_0000;
    endcase
  end

  // Control next values; override held apart from setting_group
  wire [1:0] nxt_ovr = wr_ctrl ? wb_dat_i[csta_pkg::CSTA_CTRL_OVR_POS +: 2] : ovr_ff;
  wire nxt_force_en = wr_ctrl ? wb_dat_i[csta_pkg::CSTA_CTRL_FORCE_EN_POS] : force_en_ff;
  wire [3:0] nxt_store = wr_ctrl ? wb_dat_i[csta_pkg::CSTA_CTRL_STORE_POS +: 4] : store_ff;
  wire [3:0] nxt_ien = wr_ien ? wb_dat_i[3:0] : ien_ff;

  // Extra source masks honour byte enables
  wire [31:0] xstart_wr = merge_bytes(32'(xstart_ff), wb_dat_i, wb_sel_i);
  wire [31:0] xtrip_wr = merge_bytes(32'(xtrip_ff), wb_dat_i, wb_sel_i);
  wire [N_EXTRA-1:0] nxt_xstart = wr_xs ? N_EXTRA'(xstart_wr) : xstart_ff;
  wire [N_EXTRA-1:0] nxt_xtrip = wr_xt ? N_EXTRA'(xtrip_wr) : xtrip_ff;

  // Status: set wins over clear
  wire [3:0] iclr_mask = wr_iclr ? wb_dat_i[3:0] : 4'h0;
  wire [3:0] nxt_istat = (istat_ff & ~iclr_mask) | ev_vec;
  wire [31:0] nxt_tstamp = tstamp_ff + 32'h0000_0001;

  // Counters; an event in the clearing cycle still counts
  wire clr_start = wr_cclr & wb_dat_i[0];
  wire clr_trip = wr_cclr & wb_dat_i[1];
  wire [31:0] nxt_cnt_start = next_count(cnt_start_ff, clr_start, s_on);
  wire [31:0] nxt_cnt_trip = next_count(cnt_trip_ff, clr_trip, t_on);

  // Event feed; stamp taken in the cycle the edge is seen
  csta_pkg::csta_event_t ev_new;
  csta_pkg::csta_event_t nxt_ev;
  wire nxt_ev_valid = |ev_stored;
  assign ev_new = '{id: ev_id, tstamp: tstamp_ff};
  assign nxt_ev = nxt_ev_valid ? ev_new : ev_ff;

  // Bus answer; read data held until the next read
  wire nxt_ack = bus_req;
  wire [31:0] nxt_dat = (bus_req & ~wb_we_i) ? rd : dat_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ovr_ff <= csta_pkg::CSTA_OVR_NORMAL;
    end else begin
      ovr_ff <= nxt_ovr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      force_en_ff <= 1'b0;
    end else begin
      force_en_ff <= nxt_force_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      store_ff <= csta_pkg::CSTA_STORE_RST;
    end else begin
      store_ff <= nxt_store;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ien_ff <= 4'h0;
    end else begin
      ien_ff <= nxt_ien;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      xstart_ff <= N_EXTRA'(csta_pkg::CSTA_EXTRA_RST);
    end else begin
      xstart_ff <= nxt_xstart;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      xtrip_ff <= N_EXTRA'(csta_pkg::CSTA_EXTRA_RST);
    end else begin
      xtrip_ff <= nxt_xtrip;
    end
  end

  // Common outputs registered one cycle after their inputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      common_start_ff <= 1'b0;
      common_trip_ff <= 1'b0;
    end else begin
      common_start_ff <= nxt_common_start;
      common_trip_ff <= nxt_common_trip;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tstamp_ff <= 32'h0000_0000;
    end else begin
      tstamp_ff <= nxt_tstamp;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      istat_ff <= 4'h0;
    end else begin
      istat_ff <= nxt_istat;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_start_ff <= csta_pkg::CSTA_CNT_RST;
    end else begin
      cnt_start_ff <= nxt_cnt_start;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_trip_ff <= csta_pkg::CSTA_CNT_RST;
    end else begin
      cnt_trip_ff <= nxt_cnt_trip;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ev_valid_ff <= 1'b0;
      ev_ff <= '0;
    end else begin
      ev_valid_ff <= nxt_ev_valid;
      ev_ff <= nxt_ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign common_out = '{start: common_start_ff, trip: common_trip_ff};
  assign ev_valid = ev_valid_ff;
  assign ev_data = ev_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign irq = |(istat_ff & ien_ff);
endmodule // csta_aggregator

// *** hdl/csta_pkg.sv ***
// Package for the common start/trip aggregator: register map, fields, types.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package csta_pkg;
  // Register byte offsets
  localparam logic [7:0] CSTA_CTRL_OFS = 8'h00;
  localparam logic [7:0] CSTA_COND_OFS = 8'h04;
  localparam logic [7:0] CSTA_ISTAT_OFS = 8'h08;
  localparam logic [7:0] CSTA_ICLR_OFS = 8'h0c;
  localparam logic [7:0] CSTA_IEN_OFS = 8'h10;
  localparam logic [7:0] CSTA_CNT_START_OFS = 8'h14;
  localparam logic [7:0] CSTA_CNT_TRIP_OFS = 8'h18;
  localparam logic [7:0] CSTA_CNT_CLR_OFS = 8'h1c;
  localparam logic [7:0] CSTA_EXTRA_START_OFS = 8'h20;
  localparam logic [7:0] CSTA_EXTRA_TRIP_OFS = 8'h24;
  localparam logic [7:0] CSTA_TSTAMP_OFS = 8'h28;
  // Control fields
  localparam int CSTA_CTRL_OVR_POS = 0;
  localparam int CSTA_CTRL_FORCE_EN_POS = 2;
  localparam int CSTA_CTRL_STORE_POS = 4;
  // Event bit positions
  localparam int CSTA_EV_START_ON = 0;
  localparam int CSTA_EV_START_OFF = 1;
  localparam int CSTA_EV_TRIP_ON = 2;
  localparam int CSTA_EV_TRIP_OFF = 3;
  localparam int CSTA_NUM_EV = 4;
  // Reset values
  localparam logic [3:0] CSTA_STORE_RST = 4'hf;
  localparam logic [31:0] CSTA_EXTRA_RST = 32'h0000_0000;
  localparam logic [31:0] CSTA_CNT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    CSTA_OVR_NORMAL = 2'h0,
    CSTA_OVR_START = 2'h1,
    CSTA_OVR_TRIP = 2'h2
  } csta_cond_t;

  typedef struct packed {
    logic [3:0] id;
    logic [31:0] tstamp;
  } csta_event_t;

  typedef struct packed {
    logic start;
    logic trip;
  } csta_common_t;
endpackage

// *** hdl/csta_edge.sv ***
// Edge detector for one common output: ON and OFF pulses.
// Assumes input is on the same clock.
`timescale 1ns/10ps
module csta_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Level in, pulses out
  input wire logic level,
  output logic on_pulse,
  output logic off_pulse
);
  logic prev_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level;
    end
  end

  assign on_pulse = level & ~prev_ff;
  assign off_pulse = ~level & prev_ff;
endmodule // csta_edge

// *** tb/csta_chk.sv ***
// Checker: port-level assertions for the aggregator.
// Assumes one clock domain and a bind from the bench top file.
`timescale 1ns/10ps
module csta_chk #(
  parameter int N_STAGES = 8,
  parameter int N_EXTRA = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic [N_STAGES-1:0] stage_start,
  input wire logic [N_STAGES-1:0] stage_trip,
  input wire logic [N_EXTRA-1:0] extra_src,
  input csta_pkg::csta_common_t common_out,
  input wire logic ev_valid,
  input csta_pkg::csta_event_t ev_data,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Reported id must match a real change seen one cycle earlier
  property p_ev(logic [3:0] k, logic s, logic on);
    ev_valid && ev_data.id == k |-> $past(s) == on && $past(s, 2) != on;
  endproperty
  AST_START_ANY: assert property ((|stage_start) |=> common_out.start) else $error("start lost");
  AST_TRIP_ANY: assert property ((|stage_trip) |=> common_out.trip) else $error("trip lost");
  AST_EV_SON: assert property (p_ev(4'h0, common_out.start, 1'b1)) else $error("bad start on");
  AST_EV_SOFF: assert property (p_ev(4'h1, common_out.start, 1'b0)) else $error("bad start off");
  AST_EV_TON: assert property (p_ev(4'h2, common_out.trip, 1'b1)) else $error("bad trip on");
  AST_EV_TOFF: assert property (p_ev(4'h3, common_out.trip, 1'b0)) else $error("bad trip off");
  // Setting group alone must never raise start
  AST_START_CAUSE: assert property ($rose(common_out.start) |-> $past(|stage_start) || $past(|extra_src)
    || wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("start without cause");
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  COV_SON: cover property (ev_valid && ev_data.id == 4'h0);
  COV_TOFF: cover property (ev_valid && ev_data.id == 4'h3);
  COV_TRIP: cover property ($rose(common_out.trip));
endmodule // csta_chk

// *** tb/csta_stage_model.sv ***
// Model of the protection stages feeding start and trip levels.
// Assumes the bench sets requested levels; outputs move on the rising edge.
`timescale 1ns/10ps
module csta_stage_model #(
  parameter int N_STAGES = 8
) (
  // Clock
  input wire logic clk,
  // Requested levels
  input wire logic [N_STAGES-1:0] req_start,
  input wire logic [N_STAGES-1:0] req_trip,
  // Stage outputs
  output logic [N_STAGES-1:0] stage_start = '0,
  output logic [N_STAGES-1:0] stage_trip = '0
);
  // Stages do their own blocking, so no block line exists here
  always @(posedge clk) begin
    stage_start <= req_start;
    stage_trip <= req_trip;
  end
endmodule // csta_stage_model

// *** tb/test_common_start_trip_aggregator.sv ***
// Bench: Wishbone sequences with expected values for the aggregator.
// Assumes checker and stage model are compiled first.
`timescale 1ns/10ps
module test_common_start_trip_aggregator;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] rq_s = 8'h00;
  logic [7:0] rq_t = 8'h00;
  logic [7:0] st_s;
  logic [7:0] st_t;
  logic [31:0] ext = 32'h0;
  logic [2:0] sg = 3'h0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdo;
  logic [31:0] rdat;
  logic [31:0] ts0;
  logic ack;
  logic irq;
  logic evv;
  csta_pkg::csta_common_t co;
  csta_pkg::csta_event_t ev;
  int num_errors = 0;
  int n_compared = 0;
  int n_ev = 0;
  int n0;
  always #25 clk = ~clk;
  // Counted mid-cycle so a check on the next rising edge sees the new count
  always @(negedge clk) if (evv === 1'b1) n_ev <= n_ev + 1;
  csta_stage_model i_stg (.clk(clk), .req_start(rq_s), .req_trip(rq_t), .stage_start(st_s), .stage_trip(st_t));
  csta_aggregator i_dut (.clk(clk), .rst_b(rst_b), .stage_start(st_s), .stage_trip(st_t), .extra_src(ext),
    .setting_group(sg), .common_out(co), .ev_valid(evv), .ev_data(ev), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack), .irq(irq));
  task automatic finish_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is sampled, then releases for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic got_ack;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    got_ack = (ack === 1'b1);
    rdat = rdo;
    cyc <= 1'b0;
    @(posedge clk);
    if (!got_ack) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h00, 32'h0000_00f0);
    rd(8'h04, 32'h0);
    rd(8'h3c, 32'h0);
    $display("test reset done");
    rq_s <= 8'h08;
    repeat (4) @(posedge clk);
    chk({30'h0, co}, 32'h2);
    ts0 = ev.tstamp;
    rd(8'h04, 32'h1);
    rq_t <= 8'h01;
    repeat (4) @(posedge clk);
    chk({30'h0, co}, 32'h3);
    chk({31'h0, ev.tstamp > ts0}, 32'h1);
    chk({28'h0, ev.id}, 32'h2);
    rd(8'h04, 32'h2);
    rq_t <= 8'h00;
    repeat (4) @(posedge clk);
    rq_s <= 8'h00;
    repeat (4) @(posedge clk);
    chk({30'h0, co}, 32'h0);
    chk(n_ev, 32'h4);
    rd(8'h08, 32'hf);
    rd(8'h14, 32'h1);
    rd(8'h18, 32'h1);
    $display("test stages done");
    wb(1'b1, 8'h10, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h0c, 32'hf);
    chk({31'h0, irq}, 32'h0);
    rd(8'h08, 32'h0);
    wb(1'b1, 8'h1c, 32'h3);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    $display("test irq done");
    wb(1'b1, 8'h20, 32'h100);
    wb(1'b1, 8'h24, 32'h100);
    ext <= 32'h100;
    repeat (3) @(posedge clk);
    chk({30'h0, co}, 32'h3);
    ext <= 32'h200;
    repeat (3) @(posedge clk);
    chk({30'h0, co}, 32'h0);
    $display("test extra done");
    n0 = n_ev;
    wb(1'b1, 8'h00, 32'h1);
    repeat (3) @(posedge clk);
    chk({30'h0, co}, 32'h0);
    wb(1'b1, 8'h00, 32'h5);
    repeat (3) @(posedge clk);
    chk({30'h0, co}, 32'h2);
    sg <= 3'h5;
    repeat (3) @(posedge clk);
    chk({30'h0, co}, 32'h2);
    wb(1'b1, 8'h00, 32'h6);
    repeat (3) @(posedge clk);
    chk({30'h0, co}, 32'h1);
    rd(8'h04, 32'h2);
    chk(n_ev, n0);
    rd(8'h14, 32'h2);
    rd(8'h18, 32'h2);
    $display("test override done");
    // Reset in mid-run while the override forces trip
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk({30'h0, co}, 32'h0);
    rd(8'h00, 32'h0000_00f0);
    rd(8'h14, 32'h0);
    chk(n_ev, n0);
    $display("test mid reset done");
    finish_test();
  end
endmodule // test_common_start_trip_aggregator
bind csta_aggregator csta_chk #(.N_STAGES(N_STAGES), .N_EXTRA(N_EXTRA)) i_chk (.clk(clk), .rst_b(rst_b),
  .stage_start(stage_start), .stage_trip(stage_trip), .extra_src(extra_src), .common_out(common_out),
  .ev_valid(ev_valid), .ev_data(ev_data), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
